// [hw/tpcp_top.sv]
// three-phase complementary pwm timer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module tpcp_top #(
  parameter int TICK_DIV = tpcp_pkg::DEF_TICK_DIV
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [tpcp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tpcp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ch3_toggle_pin,
  output logic phase_u_positive_pin,
  output logic phase_u_positive_oe_n,
  output logic phase_v_positive_pin,
  output logic phase_v_positive_oe_n,
  output logic phase_w_positive_pin,
  output logic phase_w_positive_oe_n,
  output logic phase_u_negative_pin,
  output logic phase_u_negative_oe_n,
  output logic phase_v_negative_pin,
  output logic phase_v_negative_oe_n,
  output logic phase_w_negative_pin,
  output logic phase_w_negative_oe_n,
  output logic ch3_compare_a_interrupt,
  output logic [3:0] ch3_compare_priority
);
  import tpcp_pkg::*;

  if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
    $error("TICK_DIV out of range");
  end

  // register file
  logic [15:0] prio_q, prio_d, lim_q, lim_d, limb_q, limb_d, dead_q, dead_d;
  logic [15:0] up_q, up_d, upb_q, upb_d;
  logic [15:0] duty_q [3];
  logic [15:0] duty_d [3];
  logic [15:0] dbuf_q [3];
  logic [15:0] dbuf_d [3];
  logic [7:0] md3_q, md3_d, md4_q, md4_d, ie_q, ie_d, oe_q, oe_d;
  logic [7:0] lvl_q, lvl_d, start_q, start_d;
  logic flag_q, flag_d, irq_q, irq_d, tog_q, tog_d, tick_q, tick_d;
  logic [15:0] div_q, div_d;
  // bus state
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] wr_idx_q, wr_idx_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  // timer state
  logic [15:0] cnt3, cnt4;
  logic down3, down4, run3, run4, cpwm, peak, trough, xfer, match_a, wr_go;
  logic ld3, ld4;
  logic [6:0] pin_w, oen_w;

  function automatic logic [15:0] m16(input logic [15:0] o, input logic [31:0] d,
                                      input logic [3:0] s);
    m16 = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  function automatic logic [7:0] m8(input logic [7:0] o, input logic [31:0] d,
                                    input logic [3:0] s);
    m8 = s[0] ? d[7:0] : o;
  endfunction

  // {hit, data}; unmapped indices read as zero with the hit bit low
  function automatic logic [32:0] rd_word(input logic [31:0] ix);
    case (ix)
      IX_PRIO: rd_word = {17'h10000, prio_q};
      IX_CH3_MODE: rd_word = {25'h1000000, md3_q};
      IX_CH4_MODE: rd_word = {25'h1000000, md4_q};
      IX_CH3_IE: rd_word = {25'h1000000, ie_q};
      IX_OUT_EN: rd_word = {25'h1000000, oe_q};
      IX_OUT_LEVEL: rd_word = {25'h1000000, lvl_q};
      IX_CH3_CNT: rd_word = {17'h10000, cnt3};
      IX_CH4_CNT: rd_word = {17'h10000, cnt4};
      IX_HALF_LIM: rd_word = {17'h10000, lim_q};
      IX_DEAD: rd_word = {17'h10000, dead_q};
      IX_CH3_UPPER: rd_word = {17'h10000, up_q};
      IX_DUTY_U: rd_word = {17'h10000, duty_q[0]};
      IX_DUTY_V: rd_word = {17'h10000, duty_q[1]};
      IX_DUTY_W: rd_word = {17'h10000, duty_q[2]};
      IX_HALF_BUF: rd_word = {17'h10000, limb_q};
      IX_CH3_UPPER_BUF: rd_word = {17'h10000, upb_q};
      IX_DUTY_U_BUF: rd_word = {17'h10000, dbuf_q[0]};
      IX_DUTY_V_BUF: rd_word = {17'h10000, dbuf_q[1]};
      IX_DUTY_W_BUF: rd_word = {17'h10000, dbuf_q[2]};
      IX_CH3_STATUS: rd_word = {32'h80000000, flag_q};
      IX_START: rd_word = {25'h1000000, start_q};
      default: rd_word = 33'h000000000;
    endcase
  endfunction

  // AXI4-Lite slave: one write and one read in flight
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_go = aw_hold_q && w_hold_q && !bvalid_q;

  always_comb begin
    logic [32:0] rw;
    logic [32:0] ww;
    rw = rd_word(s_axi_araddr[ADDR_W-1:2]);
    // a function result cannot be bit-selected directly
    ww = rd_word(wr_idx_q);
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    wr_idx_d = wr_idx_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      wr_idx_d = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ww[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = rw[31:0];
      rresp_d = rw[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      wr_idx_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      wr_idx_q <= wr_idx_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // timer events
  assign cpwm = md3_q[3:0] == MD_CPWM1 || md3_q[3:0] == MD_CPWM2
             || md3_q[3:0] == MD_CPWM3;
  assign run3 = start_q[B_CH3_START];
  assign run4 = start_q[B_CH4_START];
  assign peak = tick_q && run3 && cpwm && !down3 && cnt3 >= up_q;
  assign trough = tick_q && run4 && cpwm && down4 && cnt4 == 16'h0000;
  assign xfer = (peak && md3_q[3:0] != MD_CPWM2)
             || (trough && md3_q[3:0] != MD_CPWM1);
  assign match_a = tick_q && run3 && cnt3 == up_q;
  assign ld3 = wr_go && wr_idx_q == IX_CH3_CNT;
  assign ld4 = wr_go && wr_idx_q == IX_CH4_CNT;

  always_comb begin
    prio_d = prio_q;
    md3_d = md3_q;
    md4_d = md4_q;
    ie_d = ie_q;
    oe_d = oe_q;
    lvl_d = lvl_q;
    lim_d = lim_q;
    limb_d = limb_q;
    dead_d = dead_q;
    up_d = up_q;
    upb_d = upb_q;
    duty_d = duty_q;
    dbuf_d = dbuf_q;
    start_d = start_q;
    flag_d = flag_q;
    div_d = (div_q == 16'(TICK_DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
    tick_d = div_q == 16'(TICK_DIV - 1);
    tog_d = tog_q;
    if (wr_go) begin
      case (wr_idx_q)
        IX_PRIO: prio_d = m16(prio_q, wdata_q, wstrb_q);
        IX_CH3_MODE: md3_d = m8(md3_q, wdata_q, wstrb_q);
        IX_CH4_MODE: md4_d = m8(md4_q, wdata_q, wstrb_q);
        IX_CH3_IE: ie_d = m8(ie_q, wdata_q, wstrb_q);
        IX_OUT_EN: oe_d = m8(oe_q, wdata_q, wstrb_q);
        IX_OUT_LEVEL: begin
          if (wstrb_q[0]) begin
            lvl_d[B_TOGGLE_SYNC] = wdata_q[B_TOGGLE_SYNC];
            // the lock only sets; reset is the one way out
            lvl_d[B_LOCK] = lvl_q[B_LOCK] | wdata_q[B_LOCK];
            if (!lvl_q[B_LOCK]) begin
              lvl_d[B_OCS] = wdata_q[B_OCS];
              lvl_d[B_ANTI_LVL] = wdata_q[B_ANTI_LVL];
              lvl_d[B_POS_LVL] = wdata_q[B_POS_LVL];
            end
          end
        end
        IX_HALF_LIM: lim_d = m16(lim_q, wdata_q, wstrb_q);
        IX_HALF_BUF: limb_d = m16(limb_q, wdata_q, wstrb_q);
        IX_DEAD: dead_d = m16(dead_q, wdata_q, wstrb_q);
        IX_CH3_UPPER: up_d = m16(up_q, wdata_q, wstrb_q);
        IX_CH3_UPPER_BUF: upb_d = m16(upb_q, wdata_q, wstrb_q);
        IX_DUTY_U: duty_d[0] = m16(duty_q[0], wdata_q, wstrb_q);
        IX_DUTY_V: duty_d[1] = m16(duty_q[1], wdata_q, wstrb_q);
        IX_DUTY_W: duty_d[2] = m16(duty_q[2], wdata_q, wstrb_q);
        IX_DUTY_U_BUF: dbuf_d[0] = m16(dbuf_q[0], wdata_q, wstrb_q);
        IX_DUTY_V_BUF: dbuf_d[1] = m16(dbuf_q[1], wdata_q, wstrb_q);
        IX_DUTY_W_BUF: dbuf_d[2] = m16(dbuf_q[2], wdata_q, wstrb_q);
        IX_CH3_STATUS: begin
          if (wstrb_q[0] && !wdata_q[B_CMPA_FLAG]) begin
            flag_d = 1'b0;
          end
        end
        IX_START: start_d = m8(start_q, wdata_q, wstrb_q);
        default: begin
        end
      endcase
    end
    // transfers come last so a same-cycle direct write cannot undo them
    if (xfer) begin
      lim_d = limb_q;
      if (md3_q[B_BUF_A]) begin
        up_d = upb_q;
        duty_d[1] = dbuf_q[1];
      end
      if (md3_q[B_BUF_B]) begin
        duty_d[0] = dbuf_q[0];
        duty_d[2] = dbuf_q[2];
      end
    end
    if (match_a) begin
      flag_d = 1'b1;
    end
    if (lvl_q[B_TOGGLE_SYNC] && (peak || trough)) begin
      tog_d = !tog_q;
    end
    irq_d = flag_d && ie_d[B_CMPA_IE];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prio_q <= RST_HALF;
      md3_q <= RST_BYTE;
      md4_q <= RST_BYTE;
      ie_q <= RST_BYTE;
      oe_q <= RST_BYTE;
      lvl_q <= RST_BYTE;
      lim_q <= RST_LIMIT;
      limb_q <= RST_LIMIT;
      dead_q <= RST_HALF;
      up_q <= RST_LIMIT;
      upb_q <= RST_LIMIT;
      duty_q <= '{default: RST_LIMIT};
      dbuf_q <= '{default: RST_LIMIT};
      start_q <= RST_BYTE;
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      tog_q <= 1'b0;
      div_q <= RST_HALF;
      tick_q <= 1'b0;
    end else begin
      prio_q <= prio_d;
      md3_q <= md3_d;
      md4_q <= md4_d;
      ie_q <= ie_d;
      oe_q <= oe_d;
      lvl_q <= lvl_d;
      lim_q <= lim_d;
      limb_q <= limb_d;
      dead_q <= dead_d;
      up_q <= up_d;
      upb_q <= upb_d;
      duty_q <= duty_d;
      dbuf_q <= dbuf_d;
      start_q <= start_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      tog_q <= tog_d;
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // ch3 turns between dead time and its upper limit, so software must
  // preload the count with the dead time to keep the offset
  tpcp_updown #(.W(16)) u_cnt3 (
    .clk(clk),
    .srst(srst),
    .tick(tick_q),
    .run(run3),
    .updown(cpwm),
    .lo(dead_q),
    .hi(up_q),
    .ld(ld3),
    .ld_val(m16(cnt3, wdata_q, wstrb_q)),
    .cnt(cnt3),
    .down(down3)
  );

  // ch4 mode register is stored but never steers ch4 while complementary
  tpcp_updown #(.W(16)) u_cnt4 (
    .clk(clk),
    .srst(srst),
    .tick(tick_q),
    .run(run4),
    .updown(cpwm),
    .lo(RST_HALF),
    .hi(lim_q),
    .ld(ld4),
    .ld_val(m16(cnt4, wdata_q, wstrb_q)),
    .cnt(cnt4),
    .down(down4)
  );

  for (genvar p = 0; p < 3; p++) begin : g_phase
    tpcp_phase u_phase (
      .clk(clk),
      .srst(srst),
      .run(run3 && run4 && cpwm),
      .c3(cnt3),
      .c4(cnt4),
      .duty(duty_q[p]),
      .pos_lvl(lvl_q[B_POS_LVL]),
      .neg_lvl(lvl_q[B_ANTI_LVL]),
      .oe_pos(oe_q[p]),
      .oe_neg(oe_q[p+3]),
      .pos_pin(pin_w[p]),
      .pos_oe_n(oen_w[p]),
      .neg_pin(pin_w[p+3]),
      .neg_oe_n(oen_w[p+3])
    );
  end
  assign pin_w[6] = 1'b0;
  assign oen_w[6] = 1'b1;

  assign phase_u_positive_pin = pin_w[0];
  assign phase_u_positive_oe_n = oen_w[0];
  assign phase_v_positive_pin = pin_w[1];
  assign phase_v_positive_oe_n = oen_w[1];
  assign phase_w_positive_pin = pin_w[2];
  assign phase_w_positive_oe_n = oen_w[2];
  assign phase_u_negative_pin = pin_w[3];
  assign phase_u_negative_oe_n = oen_w[3];
  assign phase_v_negative_pin = pin_w[4];
  assign phase_v_negative_oe_n = oen_w[4];
  assign phase_w_negative_pin = pin_w[5];
  assign phase_w_negative_oe_n = oen_w[5];
  assign ch3_toggle_pin = tog_q;
  assign ch3_compare_a_interrupt = irq_q;
  assign ch3_compare_priority = prio_q[PRIO_LSB+3:PRIO_LSB];

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_lock_hold;
    lvl_q[B_LOCK] && wr_go && wr_idx_q == IX_OUT_LEVEL |=> $stable(lvl_q[2:0]);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked level bits changed");

  property p_limit_xfer;
    xfer |=> lim_q == $past(limb_q);
  endproperty
  a_limit_xfer: assert property (p_limit_xfer) else $error("limit not reloaded");

  property p_duty_xfer;
    md3_q[3:0] == MD_CPWM3 && md3_q[B_BUF_B] && (peak || trough)
      |=> duty_q[0] == $past(dbuf_q[0]) && duty_q[2] == $past(dbuf_q[2]);
  endproperty
  a_duty_xfer: assert property (p_duty_xfer) else $error("duty not transferred");

  property p_irq;
    match_a && ie_q[B_CMPA_IE] && !wr_go |=> ch3_compare_a_interrupt;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_toggle;
    lvl_q[B_TOGGLE_SYNC] && (peak || trough) |=> ch3_toggle_pin != $past(ch3_toggle_pin);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle pin missed");

  property p_oe_off;
    !oe_q[5] |=> phase_w_negative_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven while disabled");

  property p_start_both;
    wr_go && wr_idx_q == IX_START && wstrb_q[0] && wdata_q[7:6] == 2'h3
      |=> run3 && run4;
  endproperty
  a_start_both: assert property (p_start_both) else $error("counters not started");

  property p_ch4_turn;
    cpwm && tick_q && run4 && !down4 && cnt4 == lim_q && !ld4
      |=> down4 ##0 cnt4 == $past(cnt4) - 16'h0001;
  endproperty
  a_ch4_turn: assert property (p_ch4_turn) else $error("ch4 did not turn at limit");

  c_xfer: cover property (xfer && md3_q[B_BUF_B]);
  c_irq: cover property (ch3_compare_a_interrupt);
  c_toggle: cover property (lvl_q[B_TOGGLE_SYNC] && peak);
endmodule
`default_nettype wire

// [pkg/tpcp_pkg.sv]
// shared constants for the three-phase complementary pwm block
package tpcp_pkg;
  localparam int ADDR_W = 34;
  localparam int DEF_TICK_DIV = 4;
  // register indices; byte address is four times the index
  localparam logic [31:0] IX_PRIO = 32'hFFFE0C08;
  localparam logic [31:0] IX_CH3_MODE = 32'hFFFE4202;
  localparam logic [31:0] IX_CH4_MODE = 32'hFFFE4203;
  localparam logic [31:0] IX_CH3_IE = 32'hFFFE4208;
  localparam logic [31:0] IX_OUT_EN = 32'hFFFE420A;
  localparam logic [31:0] IX_OUT_LEVEL = 32'hFFFE420E;
  localparam logic [31:0] IX_CH3_CNT = 32'hFFFE4210;
  localparam logic [31:0] IX_CH4_CNT = 32'hFFFE4212;
  localparam logic [31:0] IX_HALF_LIM = 32'hFFFE4214;
  localparam logic [31:0] IX_DEAD = 32'hFFFE4216;
  localparam logic [31:0] IX_CH3_UPPER = 32'hFFFE4218;
  localparam logic [31:0] IX_DUTY_U = 32'hFFFE421A;
  localparam logic [31:0] IX_DUTY_V = 32'hFFFE421C;
  localparam logic [31:0] IX_DUTY_W = 32'hFFFE421E;
  localparam logic [31:0] IX_HALF_BUF = 32'hFFFE4222;
  localparam logic [31:0] IX_CH3_UPPER_BUF = 32'hFFFE4224;
  localparam logic [31:0] IX_DUTY_U_BUF = 32'hFFFE4226;
  localparam logic [31:0] IX_DUTY_V_BUF = 32'hFFFE4228;
  localparam logic [31:0] IX_DUTY_W_BUF = 32'hFFFE422A;
  localparam logic [31:0] IX_CH3_STATUS = 32'hFFFE4230;
  localparam logic [31:0] IX_START = 32'hFFFE4280;
  // field positions
  localparam int B_TOGGLE_SYNC = 6;
  localparam int B_LOCK = 3;
  localparam int B_OCS = 2;
  localparam int B_ANTI_LVL = 1;
  localparam int B_POS_LVL = 0;
  localparam int B_BUF_B = 5;
  localparam int B_BUF_A = 4;
  localparam int B_CH4_START = 7;
  localparam int B_CH3_START = 6;
  localparam int B_CMPA_IE = 0;
  localparam int B_CMPA_FLAG = 0;
  localparam int PRIO_LSB = 4;
  localparam logic [3:0] MD_CPWM1 = 4'hD;
  localparam logic [3:0] MD_CPWM2 = 4'hE;
  localparam logic [3:0] MD_CPWM3 = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [15:0] RST_LIMIT = 16'hFFFF;
endpackage

// [hw/tpcp_updown.sv]
// up/down counter turning between a low and a high limit
`timescale 1ns/1ps
`default_nettype none
module tpcp_updown #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic run,
  input wire logic updown,
  input wire logic [W-1:0] lo,
  input wire logic [W-1:0] hi,
  input wire logic ld,
  input wire logic [W-1:0] ld_val,
  output logic [W-1:0] cnt,
  output logic down
);
  logic [W-1:0] cnt_q, cnt_d;
  logic down_q, down_d;

  if (W < 2) begin : g_bad_w
    $error("counter width too small");
  end

  always_comb begin
    cnt_d = cnt_q;
    down_d = down_q;
    if (ld) begin
      cnt_d = ld_val;
      down_d = 1'b0;
    end else if (tick && run) begin
      if (!updown) begin
        cnt_d = cnt_q + 1'b1;
      end else if (!down_q) begin
        // >= so a limit lowered under the count still turns
        if (cnt_q >= hi) begin
          down_d = 1'b1;
          cnt_d = cnt_q - 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end else if (cnt_q <= lo) begin
        down_d = 1'b0;
        cnt_d = cnt_q + 1'b1;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      down_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      down_q <= down_d;
    end
  end

  assign cnt = cnt_q;
  assign down = down_q;
endmodule
`default_nettype wire

// [hw/tpcp_phase.sv]
// one phase: positive and antiphase pins with dead-time gap
`timescale 1ns/1ps
`default_nettype none
module tpcp_phase (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [15:0] c3,
  input wire logic [15:0] c4,
  input wire logic [15:0] duty,
  input wire logic pos_lvl,
  input wire logic neg_lvl,
  input wire logic oe_pos,
  input wire logic oe_neg,
  output logic pos_pin,
  output logic pos_oe_n,
  output logic neg_pin,
  output logic neg_oe_n
);
  logic pos_act_q, pos_act_d, neg_act_q, neg_act_d;
  logic pos_oe_n_q, pos_oe_n_d, neg_oe_n_q, neg_oe_n_d;

  always_comb begin
    // c3 runs dead time ahead of c4, so the two regions never meet
    pos_act_d = run && (c4 >= duty);
    neg_act_d = run && (c3 < duty);
    pos_oe_n_d = !oe_pos;
    neg_oe_n_d = !oe_neg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pos_act_q <= 1'b0;
      neg_act_q <= 1'b0;
      pos_oe_n_q <= 1'b1;
      neg_oe_n_q <= 1'b1;
    end else begin
      pos_act_q <= pos_act_d;
      neg_act_q <= neg_act_d;
      pos_oe_n_q <= pos_oe_n_d;
      neg_oe_n_q <= neg_oe_n_d;
    end
  end

  // select 0: idle high, active low
  assign pos_pin = pos_act_q ? pos_lvl : !pos_lvl;
  assign neg_pin = neg_act_q ? neg_lvl : !neg_lvl;
  assign pos_oe_n = pos_oe_n_q;
  assign neg_oe_n = neg_oe_n_q;

  property p_no_overlap;
    @(posedge clk) disable iff (srst) !(pos_act_q && neg_act_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both phases active");
endmodule
`default_nettype wire

// [verif/tpcp_gate_model.sv]
// gate driver stage on the six pwm pins
`timescale 1ns/1ps
`default_nettype none
module tpcp_gate_model (
  input wire logic clk,
  input wire logic [5:0] pin,
  input wire logic [5:0] oe_n,
  output logic [15:0] n_ovl,
  output logic [15:0] n_on
);
  logic [5:0] line;
  logic [5:0] gate_on;
  // released lines float to the pull-up, which the stage reads as off
  assign line = pin | oe_n;
  // low-active gate inputs
  assign gate_on = ~line;
  initial begin
    n_ovl = 16'h0000;
    n_on = 16'h0000;
  end
  // both switches of one leg on at once would short the supply
  always @(posedge clk) begin
    if ((gate_on[2:0] & gate_on[5:3]) != 3'h0) n_ovl <= n_ovl + 16'h0001;
    if (gate_on[0]) n_on <= n_on + 16'h0001;
  end
endmodule
`default_nettype wire

// [verif/three_phase_complementary_pwm_test.sv]
// self-checking bench for the three-phase complementary pwm block
`timescale 1ns/1ps
`default_nettype none
module three_phase_complementary_pwm_test;
  import tpcp_pkg::*;
  logic clk, srst, awv, wv, arv, awr, wr_r, bv, arr, rv, tog, tog_q, irq;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] br, rr;
  logic [3:0] prio;
  logic [5:0] pin, oen;
  logic [15:0] n_ovl, n_on;
  int n_fail = 0;
  int n_compared = 0;
  int n_tog = 0;
  logic [31:0] s_ix [17] = '{IX_HALF_LIM, IX_HALF_BUF, IX_DEAD, IX_CH3_UPPER, IX_CH3_UPPER_BUF,
    IX_CH3_CNT, IX_CH4_CNT, IX_DUTY_U, IX_DUTY_V, IX_DUTY_W, IX_DUTY_U_BUF, IX_DUTY_V_BUF,
    IX_DUTY_W_BUF, IX_CH4_MODE, IX_CH3_MODE, IX_OUT_LEVEL, IX_OUT_EN};
  logic [31:0] s_val [17] = '{32'h14, 32'h14, 32'h4, 32'h18, 32'h18, 32'h4, 32'h0, 32'hA,
    32'hA, 32'hA, 32'hA, 32'hA, 32'hA, 32'h0, 32'h3F, 32'h40, 32'hFF};
  tpcp_top #(.TICK_DIV(1)) i_dut (.clk(clk), .srst(srst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .ch3_toggle_pin(tog),
    .phase_u_positive_pin(pin[0]), .phase_u_positive_oe_n(oen[0]),
    .phase_v_positive_pin(pin[1]), .phase_v_positive_oe_n(oen[1]),
    .phase_w_positive_pin(pin[2]), .phase_w_positive_oe_n(oen[2]),
    .phase_u_negative_pin(pin[3]), .phase_u_negative_oe_n(oen[3]),
    .phase_v_negative_pin(pin[4]), .phase_v_negative_oe_n(oen[4]),
    .phase_w_negative_pin(pin[5]), .phase_w_negative_oe_n(oen[5]),
    .ch3_compare_a_interrupt(irq), .ch3_compare_priority(prio));
  tpcp_gate_model i_gate (.clk(clk), .pin(pin), .oe_n(oen), .n_ovl(n_ovl), .n_on(n_on));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (tog !== tog_q) n_tog++;
    tog_q <= tog;
  end
  task automatic test_done();
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cut();
    n_fail++;
    test_done();
  endtask
  task automatic wr(input logic [31:0] ix, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awa <= {ix, 2'b00};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
    end while (!bv && n < 50);
    if (n >= 50) cut();
    chk(br, er);
  endtask
  task automatic rd(input logic [31:0] ix, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    ara <= {ix, 2'b00};
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 50);
    if (n >= 50) cut();
    chk(rdat, e);
    chk(rr, er);
  endtask
  initial begin
    srst = 1'b1;
    awv = 1'b0;
    wv = 1'b0;
    arv = 1'b0;
    awa = '0;
    ara = '0;
    wd = '0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(pin, 32'h3F);
    chk(oen, 32'h3F);
    rd(IX_OUT_LEVEL, 32'h0, RESP_OKAY);
    rd(IX_HALF_LIM, 32'hFFFF, RESP_OKAY);
    rd(IX_PRIO, 32'h0, RESP_OKAY);
    // unmapped place: refused, nothing stored
    wr(32'hFFFE4300, 32'h5A, RESP_SLVERR);
    rd(32'hFFFE4300, 32'h0, RESP_SLVERR);
    wr(IX_PRIO, 32'hF0, RESP_OKAY);
    chk(prio, 32'hF);
    rd(IX_PRIO, 32'hF0, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      wr(IX_OUT_EN, 32'h1 << i, RESP_OKAY);
      // the enable reaches the pin one clock after the register
      @(posedge clk);
      chk(oen, 6'(~(6'h01 << i)));
    end
    for (int i = 0; i < 17; i++) wr(s_ix[i], s_val[i], RESP_OKAY);
    wr(IX_CH3_IE, 32'h1, RESP_OKAY);
    // one write starts both counters so the dead-time offset holds
    wr(IX_START, 32'hC0, RESP_OKAY);
    n_tog = 0;
    repeat (200) @(posedge clk);
    chk(n_tog >= 8 && n_tog <= 11, 32'h1);
    chk(irq, 32'h1);
    rd(IX_CH3_STATUS, 32'h1, RESP_OKAY);
    chk(n_on > 0 && n_on < 200, 32'h1);
    rd(IX_START, 32'hC0, RESP_OKAY);
    wr(IX_HALF_BUF, 32'h12, RESP_OKAY);
    wr(IX_CH3_UPPER_BUF, 32'h16, RESP_OKAY);
    wr(IX_DUTY_U_BUF, 32'h6, RESP_OKAY);
    repeat (100) @(posedge clk);
    rd(IX_HALF_LIM, 32'h12, RESP_OKAY);
    rd(IX_CH3_UPPER, 32'h16, RESP_OKAY);
    rd(IX_DUTY_U, 32'h6, RESP_OKAY);
    chk(n_ovl, 32'h0);
    wr(IX_CH3_IE, 32'h0, RESP_OKAY);
    chk(irq, 32'h0);
    wr(IX_START, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(pin, 32'h3F);
    // lock is set-only, so this has to come last
    wr(IX_OUT_LEVEL, 32'h4B, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(pin, 32'h0);
    wr(IX_OUT_LEVEL, 32'h40, RESP_OKAY);
    rd(IX_OUT_LEVEL, 32'h4B, RESP_OKAY);
    test_done();
  end
endmodule
`default_nettype wire
